// [rtl/yuvu_pkg.sv]
// Package for the video surface layout unpacker: register map, fields,
// surface and message encodings, carrier structs.
// Assumes one core clock and a plain one-cycle register port.
//
// Operation
// - Video components are eight bits; a packed word holds two pixels.
// - Four packed orders exist, differing only in byte placement.
// - Red takes red-difference chroma, green luma, blue blue-difference chroma.
// - Normal order: top byte Cr, bits 23:16 second luma, then Cb, luma.
// - Planar surfaces use one row stride for luma, another for chroma.
// - Three-plane and two-plane interleaved 4:2:0 surfaces are both sampled.
// - Separately stored chroma planes use half the luma row pitch; the code uses the full luma pitch for them when chroma_full or media is set.
// - Contiguous three-plane chroma follows luma with half stride.
// - Half-pitch offsets: first plane twice height, second adds chroma height.
// - Full-pitch offsets: first plane luma height, second adds chroma height.
// - Media sampling always uses full-pitch interleaved chroma offsets.
// - Linear filtering replicates chroma to 4:4:4, so chroma is point sampled.
// - Raw surfaces only with untyped, block, scattered, atomic on buffers.
// - Raw surface addresses are byte offsets without element scaling.
package yuvu_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PITCH_W = 16;
    localparam int HEIGHT_W = 14;
    localparam int COMP_W = 8;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LUMA_PITCH = 8'h04;
    localparam logic [ADDR_W-1:0] REG_LUMA_HEIGHT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CHROMA_HEIGHT = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CHAN_SEL = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        PACKED422_NORMAL_ORDER = 2'h0,
        PACKED422_CHROMA_SWAPPED = 2'h1,
        PACKED422_LUMA_SWAPPED = 2'h2,
        PACKED422_CHROMA_LUMA_SWAPPED = 2'h3
    } yuvu_order_e;

    typedef enum logic [2:0] {
        ONE_DIMENSIONAL_SURFACE_TYPE = 3'h0,
        SURF_2D = 3'h1,
        SURF_3D = 3'h2,
        SURF_CUBE = 3'h3,
        SURF_BUFFER = 3'h4,
        STRUCTURED_BUFFER_TYPE = 3'h5
    } yuvu_surf_e;

    typedef enum logic [2:0] {
        MSG_TYPED = 3'h0,
        MSG_UNTYPED_RW = 3'h1,
        MSG_BLOCK = 3'h2,
        MSG_SCATTERED = 3'h3,
        MSG_ATOMIC = 3'h4
    } yuvu_msg_e;

    typedef enum logic [2:0] {
        KIND_LUMA = 3'h0,
        KIND_CB = 3'h1,
        KIND_CR = 3'h2,
        KIND_CHROMA_IL = 3'h3,
        KIND_RAW = 3'h4
    } yuvu_kind_e;

    localparam logic [1:0] MIP_NONE = 2'h0;
    localparam logic SEL_CR = 1'b0;
    localparam logic SEL_CB = 1'b1;
    localparam logic [1:0] CHAN_SEL_RST = 2'h2;

    // Byte lanes of a packed word
    localparam int LANE0 = 0;
    localparam int LANE1 = 8;
    localparam int LANE2 = 16;
    localparam int LANE3 = 24;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic tile_en;
        logic media;
        yuvu_surf_e surf_type;
        logic [1:0] mip_filter_setting;
        logic chroma_full;
        logic v_first;
        logic planar;
        yuvu_order_e order;
    } yuvu_ctrl_s;

    localparam int CTRL_W = $bits(yuvu_ctrl_s);
    localparam logic [CTRL_W-1:0] CTRL_RST = '0;

    typedef struct packed {
        logic [COMP_W-1:0] r;
        logic [COMP_W-1:0] g;
        logic [COMP_W-1:0] b;
    } yuvu_rgb_s;

    typedef struct packed {
        logic [COMP_W-1:0] y;
        logic [COMP_W-1:0] cb;
        logic [COMP_W-1:0] cr;
    } yuvu_ycc_s;

endpackage

// [rtl/yuvu_unpack422.sv]
// Byte steering for one packed 4:2:2 word into two pixels.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module yuvu_unpack422
    import yuvu_pkg::*;
(
    input wire logic [DATA_W-1:0] word_i,
    input wire yuvu_order_e order_i,
    output yuvu_ycc_s pix0_o,
    output yuvu_ycc_s pix1_o
);
    logic [COMP_W-1:0] y0, y1, cb, cr;

    always_comb begin
        y0 = word_i[LANE0 +: COMP_W];
        y1 = word_i[LANE2 +: COMP_W];
        cb = word_i[LANE1 +: COMP_W];
        cr = word_i[LANE3 +: COMP_W];
        case (order_i)
            PACKED422_NORMAL_ORDER: begin
                cr = word_i[LANE3 +: COMP_W];
                y1 = word_i[LANE2 +: COMP_W];
                cb = word_i[LANE1 +: COMP_W];
                y0 = word_i[LANE0 +: COMP_W];
            end
            PACKED422_CHROMA_SWAPPED: begin
                cb = word_i[LANE3 +: COMP_W];
                y1 = word_i[LANE2 +: COMP_W];
                cr = word_i[LANE1 +: COMP_W];
                y0 = word_i[LANE0 +: COMP_W];
            end
            PACKED422_LUMA_SWAPPED: begin
                y1 = word_i[LANE3 +: COMP_W];
                cr = word_i[LANE2 +: COMP_W];
                y0 = word_i[LANE1 +: COMP_W];
                cb = word_i[LANE0 +: COMP_W];
            end
            PACKED422_CHROMA_LUMA_SWAPPED: begin
                y1 = word_i[LANE3 +: COMP_W];
                cb = word_i[LANE2 +: COMP_W];
                y0 = word_i[LANE1 +: COMP_W];
                cr = word_i[LANE0 +: COMP_W];
            end
            default: ;
        endcase
    end

    // Shared chroma, own luma per pixel
    assign pix0_o = '{y: y0, cb: cb, cr: cr};
    assign pix1_o = '{y: y1, cb: cb, cr: cr};
endmodule

// [rtl/yuvu_plane_offsets.sv]
// Chroma plane row offsets and chroma row pitch for planar 4:2:0.
// Combinational; heights and pitch come from the register file.
`timescale 1ns/1ps
module yuvu_plane_offsets
    import yuvu_pkg::*;
(
    input wire logic [HEIGHT_W-1:0] luma_height_i,
    input wire logic [HEIGHT_W-1:0] chroma_height_i,
    input wire logic [PITCH_W-1:0] luma_pitch_i,
    input wire logic half_pitch_i,
    input wire logic v_first_i,
    output logic [PITCH_W-1:0] u_off_o,
    output logic [PITCH_W-1:0] v_off_o,
    output logic [PITCH_W-1:0] chroma_pitch_o
);
    logic [PITCH_W-1:0] first_off, second_off;

    always_comb begin
        // Counted in chroma rows, so half pitch doubles the luma height
        if (half_pitch_i) begin
            first_off = PITCH_W'({luma_height_i, 1'b0});
            chroma_pitch_o = luma_pitch_i >> 1;
        end else begin
            first_off = PITCH_W'(luma_height_i);
            chroma_pitch_o = luma_pitch_i;
        end
        second_off = first_off + PITCH_W'(chroma_height_i);
        if (v_first_i) begin
            v_off_o = first_off;
            u_off_o = second_off;
        end else begin
            u_off_o = first_off;
            v_off_o = second_off;
        end
    end
endmodule

// [rtl/yuvu_top.sv]
// Video surface layout unpacker: register file, packed 4:2:2 unpack,
// planar texel channel mapping and surface address generation.
// Assumes inputs synchronous to CLK_I and a master that never waits.
`timescale 1ns/1ps
module yuvu_top
    import yuvu_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    input wire logic WORD_VLD_I,
    input wire logic [DATA_W-1:0] WORD_I,
    output logic PIX_VLD_O,
    output yuvu_rgb_s PIX0_O,
    output yuvu_rgb_s PIX1_O,
    input wire logic TEXEL_VLD_I,
    input wire yuvu_ycc_s TEXEL_I,
    output logic TEXEL_VLD_O,
    output yuvu_rgb_s TEXEL_O,
    input wire logic FETCH_VLD_I,
    input wire yuvu_kind_e FETCH_KIND_I,
    input wire yuvu_msg_e FETCH_MSG_I,
    input wire logic [PITCH_W-1:0] FETCH_X_I,
    input wire logic [PITCH_W-1:0] FETCH_Y_I,
    output logic FETCH_VLD_O,
    output logic FETCH_OK_O,
    output logic [DATA_W-1:0] FETCH_ADDR_O
);
    // ****************************************************************
    // Register file
    // ****************************************************************
    yuvu_ctrl_s ctrl_r, ctrl_nxt;
    logic [PITCH_W-1:0] luma_pitch_r, luma_pitch_nxt;
    logic [HEIGHT_W-1:0] luma_height_r, luma_height_nxt;
    logic [HEIGHT_W-1:0] chroma_height_r, chroma_height_nxt;
    logic [DATA_W-1:0] base_r, base_nxt;
    logic [1:0] chan_sel_r, chan_sel_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic bad_tile, bad_1d, bad_mip, cfg_bad, half_pitch;

    // Software-side restrictions are reported in REG_STATUS; the fetch path
    // refuses planar requests while any of them is broken.
    always_comb begin
        half_pitch = !ctrl_r.chroma_full && !ctrl_r.media;
        bad_tile = ctrl_r.planar && ctrl_r.tile_en && half_pitch;
        bad_1d = ctrl_r.planar &&
            (ctrl_r.surf_type == ONE_DIMENSIONAL_SURFACE_TYPE);
        bad_mip = ctrl_r.planar &&
            (ctrl_r.mip_filter_setting != MIP_NONE);
        cfg_bad = bad_tile || bad_1d || bad_mip;
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        luma_pitch_nxt = luma_pitch_r;
        luma_height_nxt = luma_height_r;
        chroma_height_nxt = chroma_height_r;
        base_nxt = base_r;
        chan_sel_nxt = chan_sel_r;
        rdata_nxt = '0;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                REG_CTRL: ctrl_nxt = yuvu_ctrl_s'(REG_WDATA_I[CTRL_W-1:0]);
                REG_LUMA_PITCH: luma_pitch_nxt = REG_WDATA_I[PITCH_W-1:0];
                REG_LUMA_HEIGHT: luma_height_nxt = REG_WDATA_I[HEIGHT_W-1:0];
                REG_CHROMA_HEIGHT: begin
                    chroma_height_nxt = REG_WDATA_I[HEIGHT_W-1:0];
                end
                REG_BASE: base_nxt = REG_WDATA_I;
                REG_CHAN_SEL: chan_sel_nxt = REG_WDATA_I[1:0];
                default: ;
            endcase
        end
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                REG_CTRL: rdata_nxt = DATA_W'(ctrl_r);
                REG_LUMA_PITCH: rdata_nxt = DATA_W'(luma_pitch_r);
                REG_LUMA_HEIGHT: rdata_nxt = DATA_W'(luma_height_r);
                REG_CHROMA_HEIGHT: rdata_nxt = DATA_W'(chroma_height_r);
                REG_BASE: rdata_nxt = base_r;
                REG_CHAN_SEL: rdata_nxt = DATA_W'(chan_sel_r);
                REG_STATUS: begin
                    rdata_nxt = DATA_W'({bad_mip, bad_1d, bad_tile});
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_r <= yuvu_ctrl_s'(CTRL_RST);
            luma_pitch_r <= '0;
            luma_height_r <= '0;
            chroma_height_r <= '0;
            base_r <= '0;
            chan_sel_r <= CHAN_SEL_RST;
            rdata_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            luma_pitch_r <= luma_pitch_nxt;
            luma_height_r <= luma_height_nxt;
            chroma_height_r <= chroma_height_nxt;
            base_r <= base_nxt;
            chan_sel_r <= chan_sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign REG_RDATA_O = rdata_r;

    // ****************************************************************
    // Packed 4:2:2 unpack and planar texel mapping
    // ****************************************************************
    yuvu_ycc_s up0, up1;
    yuvu_rgb_s pix0_r, pix0_nxt, pix1_r, pix1_nxt, tex_r, tex_nxt;
    logic pix_vld_r, tex_vld_r;

    yuvu_unpack422 u_unpack (
        .word_i(WORD_I),
        .order_i(ctrl_r.order),
        .pix0_o(up0),
        .pix1_o(up1)
    );

    // Red and blue selectors let software swap chroma for two-plane
    // surfaces stored with the chroma pair reversed.
    function automatic yuvu_rgb_s map_rgb(yuvu_ycc_s c, logic [1:0] sel);
        yuvu_rgb_s o;
        o.r = (sel[0] == SEL_CB) ? c.cb : c.cr;
        o.g = c.y;
        o.b = (sel[1] == SEL_CR) ? c.cr : c.cb;
        return o;
    endfunction

    always_comb begin
        pix0_nxt = pix0_r;
        pix1_nxt = pix1_r;
        tex_nxt = tex_r;
        if (WORD_VLD_I) begin
            pix0_nxt = map_rgb(up0, CHAN_SEL_RST);
            pix1_nxt = map_rgb(up1, CHAN_SEL_RST);
        end
        // Chroma arrives already replicated per texel: point sampled
        if (TEXEL_VLD_I) begin
            tex_nxt = map_rgb(TEXEL_I, chan_sel_r);
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pix0_r <= '0;
            pix1_r <= '0;
            tex_r <= '0;
            pix_vld_r <= 1'b0;
            tex_vld_r <= 1'b0;
        end else begin
            pix0_r <= pix0_nxt;
            pix1_r <= pix1_nxt;
            tex_r <= tex_nxt;
            pix_vld_r <= WORD_VLD_I;
            tex_vld_r <= TEXEL_VLD_I;
        end
    end
    assign PIX_VLD_O = pix_vld_r;
    assign PIX0_O = pix0_r;
    assign PIX1_O = pix1_r;
    assign TEXEL_VLD_O = tex_vld_r;
    assign TEXEL_O = tex_r;

    // ****************************************************************
    // Address generation
    // ****************************************************************
    logic [PITCH_W-1:0] u_off, v_off, chroma_pitch;
    logic [PITCH_W-1:0] row, pitch;
    logic ok_nxt, ok_r, fvld_r, raw_msg, raw_surf;
    logic [DATA_W-1:0] addr_nxt, addr_r;

    yuvu_plane_offsets u_offsets (
        .luma_height_i(luma_height_r),
        .chroma_height_i(chroma_height_r),
        .luma_pitch_i(luma_pitch_r),
        .half_pitch_i(half_pitch),
        .v_first_i(ctrl_r.v_first),
        .u_off_o(u_off),
        .v_off_o(v_off),
        .chroma_pitch_o(chroma_pitch)
    );

    always_comb begin
        raw_msg = (FETCH_MSG_I == MSG_UNTYPED_RW) ||
            (FETCH_MSG_I == MSG_BLOCK) || (FETCH_MSG_I == MSG_SCATTERED) ||
            (FETCH_MSG_I == MSG_ATOMIC);
        raw_surf = (ctrl_r.surf_type == SURF_BUFFER) ||
            (ctrl_r.surf_type == STRUCTURED_BUFFER_TYPE);
        row = FETCH_Y_I;
        pitch = luma_pitch_r;
        ok_nxt = !ctrl_r.planar || !cfg_bad;
        case (FETCH_KIND_I)
            KIND_CB: begin
                row = u_off + FETCH_Y_I;
                pitch = chroma_pitch;
                ok_nxt = ctrl_r.planar && !cfg_bad;
            end
            KIND_CR: begin
                row = v_off + FETCH_Y_I;
                pitch = chroma_pitch;
                ok_nxt = ctrl_r.planar && !cfg_bad;
            end
            KIND_CHROMA_IL: begin
                row = (ctrl_r.v_first ? v_off : u_off) + FETCH_Y_I;
                pitch = chroma_pitch;
                ok_nxt = ctrl_r.planar && !half_pitch && !cfg_bad;
            end
            KIND_RAW: begin
                row = '0;
                ok_nxt = raw_msg && raw_surf;
            end
            default: ;
        endcase
        if (FETCH_KIND_I == KIND_RAW) begin
            addr_nxt = base_r + DATA_W'(FETCH_X_I);
        end else begin
            addr_nxt = base_r + DATA_W'(row) * DATA_W'(pitch) +
                DATA_W'(FETCH_X_I);
        end
        if (!FETCH_VLD_I) begin
            ok_nxt = ok_r;
            addr_nxt = addr_r;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fvld_r <= 1'b0;
            ok_r <= 1'b0;
            addr_r <= '0;
        end else begin
            fvld_r <= FETCH_VLD_I;
            ok_r <= ok_nxt;
            addr_r <= addr_nxt;
        end
    end
    assign FETCH_VLD_O = fvld_r;
    assign FETCH_OK_O = ok_r;
    assign FETCH_ADDR_O = addr_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    pix_latency_a: assert property (
        WORD_VLD_I |=> PIX_VLD_O)
        else $error("packed pixel pair not presented one cycle later");

    normal_order_a: assert property (
        WORD_VLD_I && ctrl_r.order == PACKED422_NORMAL_ORDER |=>
        PIX0_O.g == $past(WORD_I[7:0]) && PIX1_O.g == $past(WORD_I[23:16])
        && PIX0_O.r == $past(WORD_I[31:24]))
        else $error("normal order bytes misplaced");

    luma_swap_a: assert property (
        WORD_VLD_I && ctrl_r.order == PACKED422_LUMA_SWAPPED |=>
        PIX0_O.g == $past(WORD_I[15:8]) && PIX1_O.b == $past(WORD_I[7:0]))
        else $error("luma swapped order bytes misplaced");

    shared_chroma_a: assert property (
        PIX_VLD_O |-> PIX0_O.r == PIX1_O.r && PIX0_O.b == PIX1_O.b)
        else $error("pixel pair chroma differs");

    texel_map_a: assert property (
        TEXEL_VLD_I && chan_sel_r == CHAN_SEL_RST |=>
        TEXEL_O.g == $past(TEXEL_I.y) && TEXEL_O.r == $past(TEXEL_I.cr)
        && TEXEL_O.b == $past(TEXEL_I.cb))
        else $error("texel channel mapping wrong");

    raw_byte_a: assert property (
        FETCH_VLD_I && FETCH_KIND_I == KIND_RAW |=>
        FETCH_ADDR_O == $past(base_r) + DATA_W'($past(FETCH_X_I)))
        else $error("raw address scaled");

    raw_reject_a: assert property (
        FETCH_VLD_I && FETCH_KIND_I == KIND_RAW &&
        FETCH_MSG_I == MSG_TYPED |=> FETCH_VLD_O && !FETCH_OK_O)
        else $error("raw surface taken by typed message");

    half_offset_a: assert property (
        half_pitch && !ctrl_r.v_first |->
        u_off == PITCH_W'({luma_height_r, 1'b0}) &&
        v_off == PITCH_W'({luma_height_r, 1'b0}) + PITCH_W'(chroma_height_r))
        else $error("half pitch chroma offsets wrong");

    full_offset_a: assert property (
        !half_pitch && ctrl_r.v_first |->
        v_off == PITCH_W'(luma_height_r) &&
        u_off == PITCH_W'(luma_height_r) + PITCH_W'(chroma_height_r))
        else $error("full pitch chroma offsets wrong");

    media_full_a: assert property (
        ctrl_r.media |-> !half_pitch && chroma_pitch == luma_pitch_r)
        else $error("media sampling not full pitch");

    half_pitch_a: assert property (
        half_pitch |-> chroma_pitch == (luma_pitch_r >> 1))
        else $error("separate chroma pitch not half");

    cov_pair_c: cover property (WORD_VLD_I ##1 PIX_VLD_O);
    cov_raw_c: cover property (
        FETCH_VLD_I && FETCH_KIND_I == KIND_RAW ##1 FETCH_OK_O);
    cov_il_c: cover property (
        FETCH_VLD_I && FETCH_KIND_I == KIND_CHROMA_IL ##1 FETCH_OK_O);
endmodule

// [bench/yuvu_mem_model.sv]
// Graphics memory model: returns one packed word per accepted fetch.
// Assumes the fetch port of the unpacker top and one core clock.
`timescale 1ns/1ps
module yuvu_mem_model
    import yuvu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic ok_i,
    input wire logic [DATA_W-1:0] addr_i,
    output logic vld_o,
    output logic [DATA_W-1:0] word_o
);
    // ************************************************************
    // Read return
    // ************************************************************
    // Idle data is inverted so no stale word can pass for a new one
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vld_o <= 1'b0;
            word_o <= '0;
        end else if (req_i && ok_i) begin
            vld_o <= 1'b1;
            word_o <= {addr_i[7:0] ^ 8'ha5, addr_i[7:0] ^ 8'h3c,
                       addr_i[7:0] + 8'h11, addr_i[7:0]};
        end else begin
            vld_o <= 1'b0;
            word_o <= ~word_o;
        end
    end
endmodule

// [bench/yuvu_top_tb.sv]
// Testbench for the video surface unpacker: register, fetch, texel tests.
// Assumes the memory model answers fetches one cycle after acceptance.
`timescale 1ns/1ps
module yuvu_top_tb
    import yuvu_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] ra = '0;
    logic [DATA_W-1:0] rwd = '0;
    logic rwr = 1'b0;
    logic rrd = 1'b0;
    logic [DATA_W-1:0] rdata, faddr, mword;
    logic mvld, pvld, tvo, fvo, fok;
    yuvu_rgb_s pix0, pix1, texo;
    logic tvld = 1'b0;
    yuvu_ycc_s tex = '0;
    logic fvld = 1'b0;
    yuvu_kind_e fk = KIND_LUMA;
    yuvu_msg_e fm = MSG_TYPED;
    logic [PITCH_W-1:0] fx = '0;
    logic [PITCH_W-1:0] fy = '0;
    int n_mismatch = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    yuvu_top yuvu_top_inst (.CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(ra),
        .REG_WDATA_I(rwd), .REG_WR_I(rwr), .REG_RD_I(rrd),
        .REG_RDATA_O(rdata), .WORD_VLD_I(mvld), .WORD_I(mword),
        .PIX_VLD_O(pvld), .PIX0_O(pix0), .PIX1_O(pix1),
        .TEXEL_VLD_I(tvld), .TEXEL_I(tex), .TEXEL_VLD_O(tvo),
        .TEXEL_O(texo), .FETCH_VLD_I(fvld), .FETCH_KIND_I(fk),
        .FETCH_MSG_I(fm), .FETCH_X_I(fx), .FETCH_Y_I(fy),
        .FETCH_VLD_O(fvo), .FETCH_OK_O(fok), .FETCH_ADDR_O(faddr));

    yuvu_mem_model yuvu_mem_model_inst (.clk_i(clk), .rst_b_i(rst_b),
        .req_i(fvo), .ok_i(fok), .addr_i(faddr), .vld_o(mvld),
        .word_o(mword));

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1;
        chk(rdata, e);
        @(posedge clk);
        #1;
        chk(rdata, '0);
    endtask

    task automatic setc(input logic t, m, input yuvu_surf_e s,
                        input logic [1:0] mp, input logic cf, vf, pl,
                        input yuvu_order_e o);
        yuvu_ctrl_s c;
        c = '{t, m, s, mp, cf, vf, pl, o};
        wr(REG_CTRL, 32'(c));
    endtask

    task automatic fetch(input yuvu_kind_e k, input yuvu_msg_e m,
                         input logic [15:0] x, y, input logic ok,
                         input logic [31:0] e);
        @(posedge clk);
        fk <= k;
        fm <= m;
        fx <= x;
        fy <= y;
        fvld <= 1'b1;
        @(posedge clk);
        fvld <= 1'b0;
        #1;
        chk(32'(fvo), 32'h1);
        chk(32'(fok), 32'(ok));
        chk(faddr, e);
    endtask

    task automatic pix(input int o, input logic [7:0] a);
        logic [31:0] w;
        logic [7:0] cr, cb, y0, y1;
        w = {a ^ 8'ha5, a ^ 8'h3c, a + 8'h11, a};
        case (o)
            0: {cr, y1, cb, y0} = w;
            1: {cb, y1, cr, y0} = w;
            2: {y1, cr, y0, cb} = w;
            default: {y1, cb, y0, cr} = w;
        endcase
        repeat (2) @(posedge clk);
        #1;
        chk(32'(pvld), 32'h1);
        chk(32'(pix0), {8'h0, cr, y0, cb});
        chk(32'(pix1), {8'h0, cr, y1, cb});
    endtask

    task automatic tx(input yuvu_ycc_s t, input logic [23:0] e);
        @(posedge clk);
        tex <= t;
        tvld <= 1'b1;
        @(posedge clk);
        tvld <= 1'b0;
        #1;
        chk(32'(tvo), 32'h1);
        chk(32'(texo), 32'(e));
    endtask

    task automatic finish_test();
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(REG_CHAN_SEL, 32'h2);
        wr(8'h1c, 32'hffff);
        rd(8'h1c, 32'h0);
        wr(REG_STATUS, 32'h7);
        rd(REG_STATUS, 32'h0);
        $display("test registers done");
        wr(REG_BASE, 32'h100);
        for (int o = 0; o < 4; o++) begin
            setc(0, 0, SURF_BUFFER, 0, 0, 0, 0, yuvu_order_e'(o));
            fetch(KIND_RAW, MSG_UNTYPED_RW, 16'(o * 9 + 1), 7, 1,
                  32'(o * 9 + 257));
            pix(o, 8'(o * 9 + 1));
        end
        for (int m = 0; m < 5; m++) begin
            fetch(KIND_RAW, yuvu_msg_e'(m), 4, 0, m != 0, 32'h104);
        end
        setc(0, 0, STRUCTURED_BUFFER_TYPE, 0, 0, 0, 0, PACKED422_NORMAL_ORDER);
        fetch(KIND_RAW, MSG_ATOMIC, 4, 0, 1, 32'h104);
        setc(0, 0, SURF_2D, 0, 0, 0, 0, PACKED422_NORMAL_ORDER);
        fetch(KIND_RAW, MSG_BLOCK, 4, 0, 0, 32'h104);
        $display("test packed and raw done");
        wr(REG_BASE, 32'h1000);
        wr(REG_LUMA_PITCH, 32'h40);
        wr(REG_LUMA_HEIGHT, 32'h10);
        wr(REG_CHROMA_HEIGHT, 32'h8);
        setc(0, 0, SURF_2D, 0, 0, 0, 1, PACKED422_NORMAL_ORDER);
        fetch(KIND_LUMA, MSG_TYPED, 5, 2, 1, 32'h1085);
        fetch(KIND_CB, MSG_TYPED, 3, 1, 1, 32'h1423);
        fetch(KIND_CR, MSG_TYPED, 3, 1, 1, 32'h1523);
        fetch(KIND_CHROMA_IL, MSG_TYPED, 3, 1, 0, 32'h1423);
        setc(0, 0, SURF_2D, 0, 0, 1, 1, PACKED422_NORMAL_ORDER);
        fetch(KIND_CB, MSG_TYPED, 3, 1, 1, 32'h1523);
        fetch(KIND_CR, MSG_TYPED, 3, 1, 1, 32'h1423);
        setc(0, 0, SURF_2D, 0, 1, 0, 1, PACKED422_NORMAL_ORDER);
        fetch(KIND_CHROMA_IL, MSG_TYPED, 3, 1, 1, 32'h1443);
        fetch(KIND_CR, MSG_TYPED, 3, 1, 1, 32'h1643);
        setc(0, 1, SURF_2D, 0, 0, 0, 1, PACKED422_NORMAL_ORDER);
        fetch(KIND_CHROMA_IL, MSG_TYPED, 3, 1, 1, 32'h1443);
        $display("test planar offsets done");
        setc(0, 0, ONE_DIMENSIONAL_SURFACE_TYPE, 0, 1, 0, 1,
             PACKED422_NORMAL_ORDER);
        rd(REG_STATUS, 32'h2);
        fetch(KIND_LUMA, MSG_TYPED, 5, 2, 0, 32'h1085);
        setc(0, 0, SURF_2D, 1, 1, 0, 1, PACKED422_NORMAL_ORDER);
        rd(REG_STATUS, 32'h4);
        setc(1, 0, SURF_2D, 0, 0, 0, 1, PACKED422_NORMAL_ORDER);
        rd(REG_STATUS, 32'h1);
        setc(1, 0, SURF_2D, 0, 1, 0, 1, PACKED422_NORMAL_ORDER);
        rd(REG_STATUS, 32'h0);
        fetch(KIND_CHROMA_IL, MSG_TYPED, 3, 1, 1, 32'h1443);
        $display("test status done");
        tx('{8'h80, 8'h40, 8'hc0}, 24'hc08040);
        wr(REG_CHAN_SEL, 32'h1);
        rd(REG_CHAN_SEL, 32'h1);
        tx('{8'h80, 8'h40, 8'hc0}, 24'h4080c0);
        $display("test texel done");
        finish_test();
    end
endmodule
